// File: rtl/asm_cfg.svh
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

// register offsets on the control port
`define ASM_CH1_OFS 8'h0B
`define ASM_CH2_OFS 8'h0C
`define ASM_CH3_OFS 8'h0D

// slot field layout
`define ASM_SLOT_MSB 5
`define ASM_SLOT_LSB 0
`define ASM_RSVD_ZERO 2'h0

// reset values of the slot fields
`define ASM_CH1_RST 6'h00
`define ASM_CH2_RST 6'h01
`define ASM_CH3_RST 6'h02

// frame timing in bit clocks
`define ASM_WORD_BITS 32
`define ASM_CNT_W 11
`define ASM_HCNT_W 10

`endif

// File: rtl/asm_pkg.sv
`default_nettype none
package asm_pkg;
	typedef logic [5:0] asm_slot_t;
	typedef logic [31:0] asm_word_t;
	typedef logic [7:0] asm_byte_t;
	typedef logic [1:0] asm_idx_t;
	typedef enum logic [1:0] {
		ASM_FMT_TDM = 2'h0,
		ASM_FMT_I2S = 2'h1,
		ASM_FMT_LEFT_JUSTIFIED = 2'h2
	} asm_fmt_e;
endpackage : asm_pkg
`default_nettype wire

// File: rtl/asm_reg_if.sv
`default_nettype none
interface asm_reg_if;
	import asm_pkg::*;
	logic we;
	logic re;
	asm_byte_t addr;
	asm_byte_t wdata;
	asm_byte_t rdata;
	asm_slot_t slot [3];
	modport ctl (output we, output re, output addr, output wdata,
		input rdata, input slot);
	modport regs (input we, input re, input addr, input wdata,
		output rdata, output slot);
endinterface : asm_reg_if
`default_nettype wire

// File: rtl/asm_slot_regs.sv
`include "asm_cfg.svh"
`default_nettype none
module asm_slot_regs (
	input wire logic clk,
	input wire logic resetn,
	asm_reg_if.regs bus
);
	import asm_pkg::*;

	asm_slot_t slot_r [3];
	asm_byte_t rdata_r;

	// channel index for an offset, 3 when unmapped
	function automatic asm_idx_t asm_decode(input asm_byte_t a);
		if (a == `ASM_CH1_OFS) begin
			return 2'h0;
		end else if (a == `ASM_CH2_OFS) begin
			return 2'h1;
		end else if (a == `ASM_CH3_OFS) begin
			return 2'h2;
		end else begin
			return 2'h3;
		end
	endfunction : asm_decode

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_r[0] <= `ASM_CH1_RST;
			slot_r[1] <= `ASM_CH2_RST;
			slot_r[2] <= `ASM_CH3_RST;
		end else if (bus.we && asm_decode(bus.addr) != 2'h3) begin
			// only the field bits are stored
			slot_r[asm_decode(bus.addr)] <=
				bus.wdata[`ASM_SLOT_MSB:`ASM_SLOT_LSB];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= 8'h00;
		end else if (bus.re) begin
			if (asm_decode(bus.addr) != 2'h3) begin
				rdata_r <= {`ASM_RSVD_ZERO,
					slot_r[asm_decode(bus.addr)]};
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	assign bus.rdata = rdata_r;
	assign bus.slot = slot_r;

	////////////////////////////////////////////////////////////////////////
	AST_FIELD_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		bus.we && bus.addr == `ASM_CH3_OFS |=>
		slot_r[2] == $past(bus.wdata[5:0]))
		else $error("slot field not written");
	AST_FIELD_READ: assert property (@(posedge clk) disable iff (!resetn)
		bus.re && !bus.we && bus.addr == `ASM_CH2_OFS |=>
		rdata_r == {2'h0, slot_r[1]})
		else $error("slot field read back wrong");
	AST_RST_CH1: assert property (@(posedge clk)
		$rose(resetn) |-> slot_r[0] == 6'h00)
		else $error("channel one slot not zero after reset");
	AST_RST_CH2: assert property (@(posedge clk)
		$rose(resetn) |-> slot_r[1] == 6'h01)
		else $error("channel two slot not one after reset");
	AST_RST_CH3: assert property (@(posedge clk)
		$rose(resetn) |-> slot_r[2] == 6'h02)
		else $error("channel three slot not two after reset");
endmodule : asm_slot_regs
`default_nettype wire

// File: rtl/asm_channel_slot_mapper.sv
// Functional notes
// - Each of channels one to three has a six-bit read/write slot field in bits 5..0 of its register.
// - A field value 0..31 puts the channel in that TDM slot, or in that left half-frame slot for I2S/left-justified.
// - A field value 32..63 puts the channel in that TDM slot, or in right half-frame slot value minus 32.
// - After reset the channel one slot register reads zero.
// - After reset the channel two slot register holds one.
// - After reset the channel three slot register holds two.
`include "asm_cfg.svh"
`default_nettype none
module asm_channel_slot_mapper (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire asm_pkg::asm_fmt_e left_justified_format,
	input wire logic [2:0] ch_enable,
	input wire logic sample_valid,
	input wire asm_pkg::asm_word_t ch1_sample,
	input wire asm_pkg::asm_word_t ch2_sample,
	input wire asm_pkg::asm_word_t ch3_sample,
	input wire logic bclk,
	input wire logic fsync,
	output logic sdout,
	output logic sdout_oe
);
	import asm_pkg::*;

	asm_reg_if rif ();

	assign rif.we = reg_we;
	assign rif.re = reg_re;
	assign rif.addr = reg_addr;
	assign rif.wdata = reg_wdata;
	assign reg_rdata = rif.rdata;

	asm_slot_regs u_regs (
		.clk(clk),
		.resetn(resetn),
		.bus(rif.regs)
	);

	////////////////////////////////////////////////////////////////////////
	// system side: samples held stable, one toggle per update
	asm_word_t hold_r [3];
	logic xfer_tgl_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_r[0] <= 32'h0000_0000;
			hold_r[1] <= 32'h0000_0000;
			hold_r[2] <= 32'h0000_0000;
		end else if (sample_valid) begin
			hold_r[0] <= ch1_sample;
			hold_r[1] <= ch2_sample;
			hold_r[2] <= ch3_sample;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			xfer_tgl_r <= 1'b0;
		end else if (sample_valid || reg_we) begin
			xfer_tgl_r <= ~xfer_tgl_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side synchronisers
	logic fs1_r, fs2_r, fs3_r;
	logic tg1_r, tg2_r, tg3_r;
	asm_fmt_e fm1_r, fm2_r;
	logic [2:0] en1_r, en2_r;

	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			fs1_r <= 1'b0;
			fs2_r <= 1'b0;
			fs3_r <= 1'b0;
		end else begin
			fs1_r <= fsync;
			fs2_r <= fs1_r;
			fs3_r <= fs2_r;
		end
	end

	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			fm1_r <= ASM_FMT_TDM;
			fm2_r <= ASM_FMT_TDM;
			en1_r <= 3'h0;
			en2_r <= 3'h0;
			tg1_r <= 1'b0;
			tg2_r <= 1'b0;
		end else begin
			fm1_r <= left_justified_format;
			fm2_r <= fm1_r;
			en1_r <= ch_enable;
			en2_r <= en1_r;
			tg1_r <= xfer_tgl_r;
			tg2_r <= tg1_r;
		end
	end

	logic is_tdm, is_i2s, rise, fall, frame_edge, mid_edge;

	assign is_tdm = (fm2_r == ASM_FMT_TDM);
	assign is_i2s = (fm2_r == ASM_FMT_I2S);
	assign rise = fs2_r & ~fs3_r;
	assign fall = ~fs2_r & fs3_r;
	// i2s frames open on the falling edge, the other formats on the rising
	assign frame_edge = is_i2s ? fall : rise;
	assign mid_edge = ~is_tdm & (is_i2s ? rise : fall);

	////////////////////////////////////////////////////////////////////////
	// frame position counters
	logic [`ASM_CNT_W-1:0] cnt_r;
	logic [`ASM_HCNT_W-1:0] hcnt_r;
	logic right_r;
	logic active_r;

	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			hcnt_r <= '0;
			right_r <= 1'b0;
			active_r <= 1'b0;
		end else if (frame_edge) begin
			cnt_r <= '0;
			hcnt_r <= '0;
			right_r <= 1'b0;
			active_r <= 1'b1;
		end else if (mid_edge) begin
			cnt_r <= cnt_r + 1'b1;
			hcnt_r <= '0;
			right_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			hcnt_r <= hcnt_r + 1'b1;
		end
	end

	// slot code comparable with a field in every format
	function automatic asm_slot_t asm_cur_slot(input logic tdm,
			input logic [`ASM_CNT_W-1:0] c, input logic rt,
			input logic [`ASM_HCNT_W-1:0] h);
		if (tdm) begin
			return c[10:5];
		end else begin
			return {rt, h[9:5]};
		end
	endfunction : asm_cur_slot

	////////////////////////////////////////////////////////////////////////
	// frame-aligned snapshot of slots and samples
	asm_slot_t slot_b [3];
	asm_word_t word_b [3];
	logic pend_r;

	// every toggle is remembered until a frame edge applies it, so an even
	// number of updates inside one frame is not lost
	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			tg3_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			tg3_r <= tg2_r;
			// a fresh update wins over the clearing frame edge
			if (tg2_r != tg3_r) begin
				pend_r <= 1'b1;
			end else if (frame_edge) begin
				pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			slot_b[0] <= `ASM_CH1_RST;
			slot_b[1] <= `ASM_CH2_RST;
			slot_b[2] <= `ASM_CH3_RST;
			word_b[0] <= 32'h0000_0000;
			word_b[1] <= 32'h0000_0000;
			word_b[2] <= 32'h0000_0000;
		end else if (frame_edge && (pend_r || tg2_r != tg3_r)) begin
			slot_b <= rif.slot;
			word_b <= hold_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slot match, lowest channel wins a shared slot
	asm_slot_t cur;
	logic [4:0] pos;
	logic hit, bitv;

	assign cur = asm_cur_slot(is_tdm, cnt_r, right_r, hcnt_r);
	assign pos = is_tdm ? cnt_r[4:0] : hcnt_r[4:0];

	always_comb begin
		hit = 1'b0;
		bitv = 1'b0;
		for (int i = 2; i >= 0; i--) begin
			if (en2_r[i] && slot_b[i] == cur) begin
				hit = 1'b1;
				bitv = word_b[i][~pos];
			end
		end
	end

	logic sdout_r, sdout_oe_r;

	always_ff @(posedge bclk or negedge resetn) begin
		if (!resetn) begin
			sdout_r <= 1'b0;
			sdout_oe_r <= 1'b0;
		end else begin
			sdout_r <= active_r & hit & bitv;
			sdout_oe_r <= active_r & hit;
		end
	end

	assign sdout = sdout_r;
	assign sdout_oe = sdout_oe_r;

	////////////////////////////////////////////////////////////////////////
	AST_TDM_SLOT: assert property (@(posedge bclk) disable iff (!resetn)
		active_r && is_tdm && en2_r[0] && slot_b[0] == cnt_r[10:5] |=>
		sdout_oe && sdout == $past(word_b[0][~cnt_r[4:0]]))
		else $error("channel one missing from its tdm slot");
	AST_LEFT_SLOT: assert property (@(posedge bclk) disable iff (!resetn)
		active_r && !is_tdm && !right_r && en2_r[1] && !slot_b[1][5] &&
		slot_b[1][4:0] == hcnt_r[9:5] |=> sdout_oe)
		else $error("channel two missing from its left slot");
	AST_RIGHT_SLOT: assert property (@(posedge bclk) disable iff (!resetn)
		active_r && !is_tdm && right_r && en2_r[2] && slot_b[2][5] &&
		slot_b[2][4:0] == hcnt_r[9:5] |=> sdout_oe)
		else $error("channel three missing from its right slot");
	AST_IDLE_SLOT: assert property (@(posedge bclk) disable iff (!resetn)
		!hit |=> !sdout_oe && !sdout)
		else $error("unassigned slot driven");
	AST_NO_FRAME: assert property (@(posedge bclk) disable iff (!resetn)
		!active_r && !frame_edge |=> ##1 !sdout_oe)
		else $error("output driven before first frame");
endmodule : asm_channel_slot_mapper
`default_nettype wire

// File: tb/asm_host_rx.sv
`default_nettype none
module asm_host_rx (
	input wire logic bclk,
	input wire logic i2s,
	input wire logic sdout,
	input wire logic sdout_oe,
	output logic fsync = 1'b0,
	output logic done = 1'b0,
	output logic [5:0] slot = 6'h00,
	output logic [33:0] word
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [10:0] cnt = 11'h000;
	logic [10:0] pos;
	// word is {oe seen in any bit, oe held in every bit, data}
	logic [33:0] acc = 34'h0;
	// first data bit is sampled when the counter reads four
	assign pos = cnt - 11'h004;
	assign word = acc;
	always @(posedge bclk) begin
		cnt <= cnt + 11'h001;
		fsync <= (11'(cnt + 11'h001) < 11'h400) ^ i2s;
		if (pos[4:0] == 5'h00)
			acc <= {sdout_oe, sdout_oe, 31'h0, sdout};
		else
			acc <= {acc[33] | sdout_oe, acc[32] & sdout_oe, acc[30:0], sdout};
		done <= pos[4:0] == 5'h1F;
		slot <= pos[10:5];
	end
endmodule : asm_host_rx
`default_nettype wire

// File: tb/asm_channel_slot_mapper_test.sv
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module asm_channel_slot_mapper_test;
	timeunit 1ns;
	timeprecision 100ps;
	import asm_pkg::*;
	logic clk = 1'b0;
	logic bclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic re_d = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] re_e;
	asm_fmt_e fmt = ASM_FMT_TDM;
	logic [2:0] ch_en = 3'h7;
	logic sample_valid = 1'b0;
	asm_word_t smp [3] = '{32'h0, 32'h0, 32'h0};
	asm_slot_t s [3] = '{6'h00, 6'h01, 6'h02};
	logic fsync, sdout, sdout_oe, done;
	logic [5:0] slot;
	logic [33:0] word;
	logic [33:0] se;
	logic [7:0] rq [$];
	logic [33:0] sq [$];
	integer seed = 22486;
	int n_fail = 0;
	int compares = 0;

	asm_channel_slot_mapper DUT (.clk(clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata),
		.left_justified_format(fmt), .ch_enable(ch_en),
		.sample_valid(sample_valid), .ch1_sample(smp[0]),
		.ch2_sample(smp[1]), .ch3_sample(smp[2]), .bclk(bclk),
		.fsync(fsync), .sdout(sdout), .sdout_oe(sdout_oe));
	asm_host_rx host (.bclk(bclk), .i2s(fmt == ASM_FMT_I2S), .sdout(sdout),
		.sdout_oe(sdout_oe), .fsync(fsync), .done(done), .slot(slot),
		.word(word));

	////////////////////////////////////////////////////////////////////////
	initial forever #12.5 clk = ~clk;
	initial begin
		#3.3;
		forever #6 bclk = ~bclk;
	end

	task automatic complete_run;
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk);
		reg_we = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_re = 1'b1;
		rq.push_back(e);
		@(negedge clk);
		reg_re = 1'b0;
	endtask : rd

	task automatic frame_end;
		do @(negedge bclk); while (!(done === 1'b1 && slot == 6'h3F));
	endtask : frame_end

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) re_d <= reg_re;
	always @(negedge clk) begin
		if (re_d) begin
			re_e = rq.pop_front();
			`CHK(reg_rdata, re_e)
		end
	end
	always @(negedge bclk) begin
		if (done === 1'b1 && sq.size() > 0) begin
			se = sq.pop_front();
			`CHK(word, se)
		end
	end

	initial begin
		#1000000;
		n_fail++;
		complete_run;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [33:0] e;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h01);
		rd(8'h0D, 8'h02);
		wr(8'h0E, 8'h3F);
		rd(8'h0E, 8'h00);
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			fmt = asm_fmt_e'(i % 3);
			if (i > 2)
				ch_en = 3'($random(seed));
			if (i == 1)
				s = '{6'h1F, 6'h20, 6'h3F};
			if (i > 1)
				foreach (s[c]) s[c] = 6'($random(seed));
			if (i == 4)
				s[2] = s[0];
			foreach (s[c]) wr(8'(8'h0B + c), {2'b00, s[c]});
			foreach (s[c]) rd(8'(8'h0B + c), {2'b00, s[c]});
			frame_end;
			@(negedge clk);
			foreach (smp[c]) smp[c] = $random(seed);
			sample_valid = 1'b1;
			@(negedge clk);
			sample_valid = 1'b0;
			frame_end;
			#1;
			for (int t = 0; t < 64; t++) begin
				e = 34'h0;
				// lowest enabled channel on a shared slot is noted last
				for (int c = 2; c >= 0; c--)
					if (ch_en[c] && s[c] == t)
						e = {2'b11, smp[c]};
				sq.push_back(e);
			end
			frame_end;
		end
		@(negedge bclk);
		`CHK(sq.size(), 0)
		complete_run;
	end
endmodule : asm_channel_slot_mapper_test
`default_nettype wire
